// ===== common/nand_prog_consts.svh
`ifndef NAND_PROG_CONSTS_SVH
`define NAND_PROG_CONSTS_SVH

`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_PROGRAM_LOAD 8'h02
`define OP_RANDOM_LOAD 8'h84
`define OP_PROGRAM_EXECUTE 8'h10
`define OP_GET_FEATURE 8'h0F
`define FEATURE_STATUS 8'hC0

`define CACHE_BYTES 12'h840
`define COLUMN_HIGH_MASK 4'hF

`define STATUS_BUSY_BIT 0
`define STATUS_WRITE_LATCH_BIT 1
`define STATUS_PROGRAM_FAIL_BIT 3

`define FIFO_WIDTH 20
`define FIFO_DEPTH 32

`define CLOCK_MHZ 100
`define PROGRAM_BUSY_TIME_US 900
`define PROGRAM_BUSY_CYCLES (`PROGRAM_BUSY_TIME_US * `CLOCK_MHZ)
`define BUSY_TIMER_WIDTH 17

`endif

// ===== common/nand_prog_pkg.sv
package nand_prog_pkg;

  typedef enum logic [2:0]
  {
    TAG_WRITE_ENABLE = 3'h0,
    TAG_WRITE_DISABLE = 3'h1,
    TAG_LOAD = 3'h2,
    TAG_RANDOM_LOAD = 3'h3,
    TAG_DATA = 3'h4,
    TAG_EXECUTE = 3'h5
  } entry_tag_type;

  typedef struct packed
  {
    entry_tag_type tag;
    logic [16:0] arg;
  } seq_entry_type;

  typedef struct packed
  {
    logic [1:0] idx;
    logic [7:0] data;
  } link_byte_type;

  typedef struct packed
  {
    logic [16:0] row;
    logic [11:0] col;
    logic [7:0] data;
  } array_write_type;

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,
    ST_COPY = 3'b010,
    ST_WAIT = 3'b100
  } prog_state_type;

endpackage

// ===== rtl/serial_nand_program_sequencer.sv
`include "nand_prog_consts.svh"

module seq_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign push = i_in_valid && !full;
  assign pop = i_out_ready && !empty;
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
endmodule

// Notes on behaviour
// - load and execute are ignored unless the write latch is set
// - load frame: opcode, 3 dummy bits, plane bit, 12-bit column, then data
// - cache holds 2112 bytes; bytes beyond that are dropped
// - chip select rising ends the load; no further bytes are taken
// - execute frame: opcode, 7 dummy bits, 17-bit row address
// - after row capture, cache is copied to the page; busy for program time
// - host polls status while busy, loads next data only after completion
// - random load uses the same layout and writes at its own column
// - fail flag set on failure or protected target, cleared by execute or reset
// - program to a locked block reports status 08h, array untouched
module serial_nand_program_sequencer
  import nand_prog_pkg::*;
#(
  parameter int PROGRAM_CYCLES = `PROGRAM_BUSY_CYCLES
) (
  // core clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // serial link
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe,
  // array write port
  output logic o_array_valid,
  output array_write_type o_array_write,
  input wire logic i_array_ready,
  input wire logic i_array_fail,
  // protection and status
  input wire logic i_write_protect,
  output logic o_busy
);

  // link side, on i_sck
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic [1:0] byte_idx;
  logic [7:0] link_opcode;
  logic status_mode;
  logic [7:0] tx_byte;
  logic [2:0] out_cnt;
  logic [7:0] byte_in;
  link_byte_type rx_word;
  logic rx_toggle;
  logic [7:0] status_meta;
  logic [7:0] status_sync;

  // core side, on i_clk
  logic toggle_meta;
  logic toggle_sync;
  logic toggle_seen;
  logic byte_new;
  link_byte_type core_word;
  logic [7:0] opcode;
  logic [7:0] addr_high;
  logic [7:0] addr_mid;
  logic exec_sent;
  logic pend_valid;
  seq_entry_type pend;
  logic fifo_in_ready;
  logic fifo_out_valid;
  seq_entry_type fifo_out;
  logic pop;
  prog_state_type state;
  logic [`BUSY_TIMER_WIDTH-1:0] timer;
  logic write_latch_flag;
  logic program_fail;
  logic loading;
  logic [11:0] col;
  logic [11:0] copy_col;
  logic [16:0] row;
  logic [7:0] cache [`CACHE_BYTES];
  logic [7:0] status;
  logic copy_step;
  logic copy_done;
  logic timer_done;

  assign byte_in = {shift, i_si};

  // cs_n high clears the framing, so a frame never leaks into the next
  always_ff @(posedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      byte_idx <= 2'h0;
      link_opcode <= 8'h00;
      status_mode <= 1'b0;
      tx_byte <= 8'h00;
    end
    else
    begin
      shift <= byte_in[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7)
      begin
        if (byte_idx == 2'h0)
        begin
          link_opcode <= byte_in;
        end
        if (byte_idx == 2'h1 && link_opcode == `OP_GET_FEATURE && byte_in == `FEATURE_STATUS)
        begin
          status_mode <= 1'b1;
          tx_byte <= status_sync;
        end
        if (byte_idx != 2'h3)
        begin
          byte_idx <= byte_idx + 2'h1;
        end
      end
    end
  end

  // the toggle must survive frame ends, so only the device reset clears it
  always_ff @(posedge i_sck or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rx_word <= '0;
      rx_toggle <= 1'b0;
      status_meta <= 8'h00;
      status_sync <= 8'h00;
    end
    else
    begin
      status_meta <= status;
      status_sync <= status_meta;
      if (!i_cs_n && bit_cnt == 3'h7)
      begin
        rx_word <= '{idx: byte_idx, data: byte_in};
        rx_toggle <= ~rx_toggle;
      end
    end
  end

  // status shifts out msb first on falling edges, repeating per byte
  always_ff @(negedge i_sck or posedge i_cs_n)
  begin
    if (i_cs_n)
    begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
      out_cnt <= 3'h0;
    end
    else if (status_mode)
    begin
      o_so <= tx_byte[3'h7 - out_cnt];
      o_so_oe <= 1'b1;
      out_cnt <= out_cnt + 3'h1;
    end
  end

  // rx_word is stable for a whole byte time after each toggle
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      toggle_meta <= 1'b0;
      toggle_sync <= 1'b0;
      toggle_seen <= 1'b0;
      byte_new <= 1'b0;
      core_word <= '0;
    end
    else
    begin
      toggle_meta <= rx_toggle;
      toggle_sync <= toggle_meta;
      toggle_seen <= toggle_sync;
      byte_new <= toggle_sync ^ toggle_seen;
      if (toggle_sync ^ toggle_seen)
      begin
        core_word <= rx_word;
      end
    end
  end

  // a held entry is overwritten if the fifo stays full a whole byte time
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      opcode <= 8'h00;
      addr_high <= 8'h00;
      addr_mid <= 8'h00;
      exec_sent <= 1'b0;
      pend_valid <= 1'b0;
      pend <= '0;
    end
    else
    begin
      if (pend_valid && fifo_in_ready)
      begin
        pend_valid <= 1'b0;
      end
      if (byte_new)
      begin
        case (core_word.idx)
          2'h0:
          begin
            opcode <= core_word.data;
            exec_sent <= 1'b0;
            if (core_word.data == `OP_WRITE_ENABLE)
            begin
              pend <= '{tag: TAG_WRITE_ENABLE, arg: 17'h0_0000};
              pend_valid <= 1'b1;
            end
            else if (core_word.data == `OP_WRITE_DISABLE)
            begin
              pend <= '{tag: TAG_WRITE_DISABLE, arg: 17'h0_0000};
              pend_valid <= 1'b1;
            end
          end
          2'h1:
          begin
            addr_high <= core_word.data;
          end
          2'h2:
          begin
            addr_mid <= core_word.data;
            if (opcode == `OP_PROGRAM_LOAD || opcode == `OP_RANDOM_LOAD)
            begin
              // top 3 bits dummy, plane bit ignored, low 4 bits start the column
              pend.tag <= (opcode == `OP_RANDOM_LOAD) ? TAG_RANDOM_LOAD : TAG_LOAD;
              pend.arg <= {5'h00, addr_high[3:0] & `COLUMN_HIGH_MASK, core_word.data};
              pend_valid <= 1'b1;
            end
          end
          default:
          begin
            if (opcode == `OP_PROGRAM_LOAD || opcode == `OP_RANDOM_LOAD)
            begin
              pend <= '{tag: TAG_DATA, arg: {9'h000, core_word.data}};
              pend_valid <= 1'b1;
            end
            else if (opcode == `OP_PROGRAM_EXECUTE && !exec_sent)
            begin
              pend <= '{tag: TAG_EXECUTE, arg: {addr_high[0], addr_mid, core_word.data}};
              pend_valid <= 1'b1;
              exec_sent <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  seq_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) entry_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(pend_valid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(pend),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(state == ST_IDLE),
    .o_out_data(fifo_out)
  );

  // commands wait in the fifo while a program is running
  assign pop = fifo_out_valid && (state == ST_IDLE);
  assign copy_step = !o_array_valid || i_array_ready;
  assign copy_done = (copy_col == `CACHE_BYTES) && copy_step;
  assign timer_done = (timer >= `BUSY_TIMER_WIDTH'(PROGRAM_CYCLES - 1));

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      state <= ST_IDLE;
      timer <= '0;
      o_busy <= 1'b0;
      row <= 17'h0_0000;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (pop && fifo_out.tag == TAG_EXECUTE && write_latch_flag && !i_write_protect)
          begin
            row <= fifo_out.arg;
            state <= ST_COPY;
            timer <= '0;
            o_busy <= 1'b1;
          end
        end
        ST_COPY:
        begin
          if (!timer_done)
          begin
            timer <= timer + 1'b1;
          end
          if (copy_done)
          begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT:
        begin
          timer <= timer + 1'b1;
          if (timer_done)
          begin
            state <= ST_IDLE;
            o_busy <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          o_busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      write_latch_flag <= 1'b0;
      program_fail <= 1'b0;
    end
    else if (pop)
    begin
      if (fifo_out.tag == TAG_WRITE_ENABLE)
      begin
        write_latch_flag <= 1'b1;
      end
      else if (fifo_out.tag == TAG_WRITE_DISABLE)
      begin
        write_latch_flag <= 1'b0;
      end
      else if (fifo_out.tag == TAG_EXECUTE && write_latch_flag)
      begin
        // a locked target fails at once and leaves the array alone
        program_fail <= i_write_protect;
        if (i_write_protect)
        begin
          write_latch_flag <= 1'b0;
        end
      end
    end
    else if (state == ST_COPY && o_array_valid && i_array_ready && i_array_fail)
    begin
      program_fail <= 1'b1;
    end
    else if (state == ST_WAIT && timer_done)
    begin
      write_latch_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      loading <= 1'b0;
      col <= 12'h000;
    end
    else if (pop)
    begin
      if (fifo_out.tag == TAG_LOAD || fifo_out.tag == TAG_RANDOM_LOAD)
      begin
        loading <= write_latch_flag;
        col <= fifo_out.arg[11:0];
      end
      else if (fifo_out.tag == TAG_DATA && loading && col < `CACHE_BYTES)
      begin
        col <= col + 12'h001;
      end
      else if (fifo_out.tag == TAG_EXECUTE || fifo_out.tag == TAG_WRITE_DISABLE)
      begin
        loading <= 1'b0;
      end
    end
    else if (state == ST_WAIT && timer_done)
    begin
      loading <= 1'b0;
    end
  end

  // cache is plain storage; its contents after reset are whatever was last loaded
  always_ff @(posedge i_clk)
  begin
    if (pop && fifo_out.tag == TAG_DATA && loading && col < `CACHE_BYTES)
    begin
      cache[col] <= fifo_out.arg[7:0];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      o_array_valid <= 1'b0;
      o_array_write <= '0;
      copy_col <= 12'h000;
    end
    else if (state == ST_COPY)
    begin
      if (copy_step)
      begin
        if (copy_col < `CACHE_BYTES)
        begin
          o_array_valid <= 1'b1;
          o_array_write <= '{row: row, col: copy_col, data: cache[copy_col]};
          copy_col <= copy_col + 12'h001;
        end
        else
        begin
          o_array_valid <= 1'b0;
        end
      end
    end
    else
    begin
      o_array_valid <= 1'b0;
      copy_col <= 12'h000;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n)
    begin
      status <= 8'h00;
    end
    else
    begin
      status <= 8'h00;
      status[`STATUS_BUSY_BIT] <= o_busy;
      status[`STATUS_WRITE_LATCH_BIT] <= write_latch_flag;
      status[`STATUS_PROGRAM_FAIL_BIT] <= program_fail;
    end
  end

endmodule

// ===== sim/nand_host_model.sv
module nand_host_model (
  // serial link toward the device
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si,
  input wire logic i_so
);
  timeunit 1ns;
  timeprecision 100ps;

  // a real rising edge of chip select clears the link framing at start
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b0;
    o_si = 1'b1;
    #1 o_cs_n = 1'b1;
  end

  // one frame, msb first; rd_en shifts one extra byte back in
  task automatic xfer(input logic [7:0] b[$], input bit rd_en, output logic [7:0] rd);
    logic [7:0] w;
    int n;
    n = b.size() + (rd_en ? 1 : 0);
    rd = 8'h00;
    o_cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      w = (i < b.size()) ? b[i] : 8'h00;
      for (int k = 7; k >= 0; k--)
      begin
        o_si = w[k];
        #3 o_sck = 1'b1;
        if (i >= b.size())
          rd = {rd[6:0], i_so};
        #3 o_sck = 1'b0;
      end
    end
    #3 o_cs_n = 1'b1;
    // released line must not keep a stale level
    o_si = ~o_si;
    #40;
  endtask
endmodule

// ===== sim/serial_nand_program_sequencer_checker.sv
module serial_nand_program_sequencer_checker
  import nand_prog_pkg::*;
#(
  parameter int PROGRAM_CYCLES = 90000
) (
  // watched ports
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_cs_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_array_valid,
  input wire array_write_type o_array_write,
  input wire logic i_array_ready,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  logic [31:0] busy_cnt;
  always_ff @(posedge i_clk)
  begin
    if (!i_reset_n || !o_busy)
      busy_cnt <= '0;
    else
      busy_cnt <= busy_cnt + 32'h0000_0001;
  end

  a_stall_holds_word: assert property (o_array_valid && !i_array_ready |=>
    o_array_valid && $stable(o_array_write)) else $error("array word changed under stall");
  a_col_steps_up: assert property (o_array_valid && i_array_ready &&
    o_array_write.col != 12'h83F |=> o_array_valid &&
    o_array_write.col == $past(o_array_write.col) + 12'h001 &&
    o_array_write.row == $past(o_array_write.row)) else $error("copy column or row slipped");
  a_copy_stops_end: assert property (o_array_valid && i_array_ready &&
    o_array_write.col == 12'h83F |=> !o_array_valid) else $error("copy ran past cache end");
  a_col_in_cache: assert property (o_array_valid |-> o_array_write.col < 12'h840)
    else $error("copy column outside cache");
  a_copy_from_zero: assert property ($rose(o_array_valid) |-> o_array_write.col == 12'h000)
    else $error("copy did not begin at column 0");
  a_busy_starts_copy: assert property ($rose(o_busy) |-> ##[1:3] o_array_valid)
    else $error("busy without array copy");
  a_busy_covers_copy: assert property (o_array_valid |-> o_busy)
    else $error("copy outside busy period");
  a_busy_bounded: assert property (o_busy |-> busy_cnt <= PROGRAM_CYCLES + 2)
    else $error("busy longer than program time");
  a_link_quiet: assert property (i_cs_n && $past(i_cs_n) |-> !o_so_oe && !o_so)
    else $error("serial out active while deselected");
endmodule

bind serial_nand_program_sequencer serial_nand_program_sequencer_checker
  #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_cs_n(i_cs_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_array_valid(o_array_valid),
  .o_array_write(o_array_write), .i_array_ready(i_array_ready), .o_busy(o_busy));

// ===== sim/serial_nand_program_sequencer_tb.sv
`include "nand_prog_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

module serial_nand_program_sequencer_tb
  import nand_prog_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // short program time keeps the run small; still longer than a full copy
  localparam int PC = 4000;
  localparam logic [7:0] S_BUSY = 8'h01 << `STATUS_BUSY_BIT;
  localparam logic [7:0] S_WEL = 8'h01 << `STATUS_WRITE_LATCH_BIT;
  localparam logic [7:0] S_FAIL = 8'h01 << `STATUS_PROGRAM_FAIL_BIT;
  logic i_clk = 1'b0, i_reset_n = 1'b1, i_sck, i_cs_n, i_si, o_so, o_so_oe;
  logic o_array_valid, i_array_ready = 1'b1, i_array_fail = 1'b0, i_write_protect = 1'b0;
  logic o_busy;
  array_write_type o_array_write;
  logic [7:0] page [0:2111];
  logic [7:0] rd;
  logic [16:0] row_seen;
  int n_words = 0, stall = 0, n_mismatch = 0, check_count = 0, n_oe = 0;

  always #5 i_clk = ~i_clk;

  nand_host_model host (.o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si), .i_so(o_so));

  serial_nand_program_sequencer #(.PROGRAM_CYCLES(PC)) uut (.i_clk(i_clk),
    .i_reset_n(i_reset_n), .i_sck(i_sck), .i_cs_n(i_cs_n), .i_si(i_si), .o_so(o_so),
    .o_so_oe(o_so_oe), .o_array_valid(o_array_valid), .o_array_write(o_array_write),
    .i_array_ready(i_array_ready), .i_array_fail(i_array_fail),
    .i_write_protect(i_write_protect), .o_busy(o_busy));

  // array side stalls one cycle in four
  always @(negedge i_clk)
  begin
    stall++;
    i_array_ready = (stall % 4) != 0;
  end

  always @(posedge i_clk)
  begin
    if (o_array_valid && i_array_ready)
    begin
      page[o_array_write.col] = o_array_write.data;
      row_seen = o_array_write.row;
      n_words++;
    end
  end

  // link bits seen with the serial output driven
  always @(posedge i_sck)
  begin
    if (o_so_oe === 1'b1)
      n_oe++;
  end

  task automatic status_is(input logic [7:0] exp);
    int oe0;
    oe0 = n_oe;
    host.xfer('{`OP_GET_FEATURE, `FEATURE_STATUS}, 1'b1, rd);
    `CHK(rd, exp)
    `CHK(n_oe - oe0, 8)
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (o_busy === 1'b1 && n < 6000)
    begin
      @(negedge i_clk);
      n++;
    end
    `CHK(n < 6000, 1'b1)
    settle(10);
  endtask

  task automatic execute(input logic [7:0] b1, b2, b3);
    host.xfer('{`OP_PROGRAM_EXECUTE, b1, b2, b3}, 1'b0, rd);
    settle(30);
  endtask

  task automatic t_no_latch();
    // latch set, then dropped again by write disable
    host.xfer('{`OP_WRITE_ENABLE}, 1'b0, rd);
    host.xfer('{`OP_WRITE_DISABLE}, 1'b0, rd);
    status_is(8'h00);
    host.xfer('{`OP_PROGRAM_LOAD, 8'h00, 8'h00, 8'hAA}, 1'b0, rd);
    execute(8'h00, 8'h00, 8'h07);
    `CHK(o_busy, 1'b0)
    `CHK(n_words, 0)
    status_is(8'h00);
  endtask

  task automatic t_program();
    // host order: enable, loads, execute, status poll
    host.xfer('{`OP_WRITE_ENABLE}, 1'b0, rd);
    status_is(S_WEL);
    // dummy bits set on purpose; col 0x83E, third byte lies past the cache
    host.xfer('{`OP_PROGRAM_LOAD, 8'hE8, 8'h3E, 8'hA1, 8'hA2, 8'hA3}, 1'b0, rd);
    host.xfer('{`OP_RANDOM_LOAD, 8'h10, 8'h05, 8'h5A}, 1'b0, rd);
    host.xfer('{`OP_RANDOM_LOAD, 8'h00, 8'h07, 8'hC3}, 1'b0, rd);
    execute(8'hFF, 8'h23, 8'h45);
    `CHK(o_busy, 1'b1)
    status_is(S_BUSY | S_WEL);
    wait_idle();
    status_is(8'h00);
    `CHK(n_words, 2112)
    `CHK(row_seen, 17'h1_2345)
    `CHK(page[12'h83E], 8'hA1)
    `CHK(page[12'h83F], 8'hA2)
    `CHK(page[12'h005], 8'h5A)
    `CHK(page[12'h007], 8'hC3)
    execute(8'h00, 8'h00, 8'h09);
    `CHK(o_busy, 1'b0)
  endtask

  task automatic t_protect_and_fail();
    host.xfer('{`OP_WRITE_ENABLE}, 1'b0, rd);
    @(negedge i_clk);
    i_write_protect = 1'b1;
    execute(8'h00, 8'h00, 8'h05);
    `CHK(o_busy, 1'b0)
    `CHK(n_words, 2112)
    status_is(S_FAIL);
    @(negedge i_clk);
    i_write_protect = 1'b0;
    i_array_fail = 1'b1;
    // same plane, well under four programs per page
    host.xfer('{`OP_WRITE_ENABLE}, 1'b0, rd);
    execute(8'h00, 8'h00, 8'h06);
    wait_idle();
    status_is(S_FAIL);
    // a mid-run reset must clear the fail flag as well
    @(negedge i_clk);
    i_reset_n = 1'b0;
    i_array_fail = 1'b0;
    settle(6);
    i_reset_n = 1'b1;
    settle(4);
    status_is(8'h00);
    host.xfer('{`OP_WRITE_ENABLE}, 1'b0, rd);
    execute(8'h00, 8'h00, 8'h06);
    status_is(S_BUSY | S_WEL);
    wait_idle();
    status_is(8'h00);
    `CHK(n_words, 3 * 2112)
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // a real falling edge of reset is needed to clear the link byte toggle
  initial
  begin
    #1 i_reset_n = 1'b0;
    repeat (6) @(negedge i_clk);
    i_reset_n = 1'b1;
    settle(4);
    t_no_latch();
    t_program();
    t_protect_and_fail();
    close_out();
  end

  // whole run is about 12.5k cycles; allow roughly three times that
  initial
  begin
    #400_000;
    n_mismatch++;
    close_out();
  end
endmodule
